// ### common/cscs_cmp_if.sv
`timescale 1ns/1ns
interface cscs_cmp_if #(
  parameter int W = 16
);
  logic [W-1:0] result;
  logic result_valid;
  logic [W-1:0] threshold;
  logic enable;
  logic hit;
  modport ctrl (
    output result,
    output result_valid,
    output threshold,
    output enable,
    input hit
  );
  modport cmp (
    input result,
    input result_valid,
    input threshold,
    input enable,
    output hit
  );
endinterface

// ### common/cscs_pkg.sv
package cscs_pkg;
  // sfr addresses
  localparam logic [7:0] CSCS_CTRL_ADDR = 8'hB0;
  localparam logic [7:0] CSCS_THR_HI_ADDR = 8'hC4;
  localparam logic [7:0] CSCS_THR_LO_ADDR = 8'hC3;
  // control register fields
  localparam int CSCS_SENSE_ENABLE_BIT = 7;
  localparam int CSCS_END_OF_SCAN_BIT = 6;
  localparam int CSCS_CONV_DONE_BIT = 5;
  localparam int CSCS_SENSE_BUSY_BIT = 4;
  localparam int CSCS_CMP_ENABLE_BIT = 3;
  localparam int CSCS_RESERVED_BIT = 2;
  localparam int CSCS_PIN_MONITOR_BIT = 1;
  localparam int CSCS_CMP_FLAG_BIT = 0;
  // reset values
  localparam logic [7:0] CSCS_CTRL_RESET = 8'h00;
  localparam logic [7:0] CSCS_THR_RESET = 8'h00;
  localparam int CSCS_RESULT_W = 16;
endpackage

// ### verif/cscs_ctrl_props.sv
`timescale 1ns/1ns
module cscs_ctrl_props
  import cscs_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // sfr access and converter
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic conv_done_in,
  input wire logic conv_start_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  wire logic ctl = sfr_addr_in == CSCS_CTRL_ADDR;
  done_set_a: assert property (conv_done_in && ctl ##1 ctl
    |=> sfr_rdata_out[5]) else $error("done flag not set");
  // three quiet cycles, as read data may lag one write
  // read data shows the address of the previous cycle, so both must match
  done_hold_a: assert property (sfr_rdata_out[5] && ctl &&
    $past(ctl) && !sfr_wr_in && !$past(sfr_wr_in) ##1 ctl && !sfr_wr_in
    |=> sfr_rdata_out[5]) else $error("done flag lost");
  start_cause_a: assert property (conv_start_out |->
    $past(sfr_wr_in && ctl && sfr_wdata_in[4]))
    else $error("start without write");
  busy_clr_a: assert property (conv_done_in && ctl && !sfr_wr_in
    ##1 ctl && !sfr_wr_in |=> !sfr_rdata_out[4])
    else $error("busy after done");
  cmp_cause_a: assert property (!sfr_rdata_out[0] && ctl &&
    $past(ctl) && !conv_done_in && !$past(conv_done_in) ##1 ctl &&
    !conv_done_in
    |=> !sfr_rdata_out[0]) else $error("compare flag without result");
endmodule
bind cscs_ctrl cscs_ctrl_props u_props (.clk_in(clk_in),
  .nrst_in(nrst_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
  .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
  .conv_done_in(conv_done_in), .conv_start_out(conv_start_out));

// ### verif/cscs_ctrl_test.sv
`timescale 1ns/1ns
`define CHK(n,e,g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module cscs_ctrl_test
  import cscs_pkg::*;
;
  logic clk_in, nrst_in, sfr_wr_in, conv_done_in, conv_start_out, sen;
  logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out;
  logic [15:0] res;
  int fails, checks, starts;
  cscs_ctrl dut (.clk_in(clk_in), .nrst_in(nrst_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
    .conv_done_in(conv_done_in), .conv_result_in(res),
    .scan_done_in(1'b0), .pin_monitor_in(1'b0),
    .conv_start_out(conv_start_out), .sense_enable_out(sen));
  initial
  begin
    clk_in = 0;
    forever #10 clk_in = ~clk_in;
  end
  // start pulses are one cycle wide, so count them as they pass
  always @(posedge clk_in) if (conv_start_out) starts++;
  task wr(input logic [7:0] a, d);
    sfr_addr_in <= a; sfr_wdata_in <= d; sfr_wr_in <= 1;
    @(posedge clk_in) sfr_wr_in <= 0;
    @(posedge clk_in);
  endtask
  task rd(input logic [7:0] a, e);
    sfr_addr_in <= a;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in) `CHK("rdata", e, sfr_rdata_out)
    @(posedge clk_in);
  endtask
  task done(input logic [15:0] r);
    conv_done_in <= 1; res <= r;
    @(posedge clk_in) conv_done_in <= 0;
    @(posedge clk_in);
  endtask
  task results;
    if (fails == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    {nrst_in, sfr_wr_in, conv_done_in, sfr_addr_in, sfr_wdata_in} = 0;
    {res, fails, checks, starts} = 0;
    repeat (10) @(posedge clk_in);
    nrst_in <= 1;
    @(posedge clk_in);
    rd(CSCS_CTRL_ADDR, CSCS_CTRL_RESET);
    rd(CSCS_THR_HI_ADDR, CSCS_THR_RESET);
    wr(CSCS_CTRL_ADDR, 8'h10);
    `CHK("start", 0, starts)
    wr(CSCS_CTRL_ADDR, 8'h80);
    `CHK("enable", 1'b1, sen)
    wr(CSCS_THR_HI_ADDR, 8'h00);
    wr(CSCS_THR_LO_ADDR, 8'h10);
    wr(CSCS_CTRL_ADDR, 8'h98);
    rd(CSCS_CTRL_ADDR, 8'h98);
    done(16'h0011);
    rd(CSCS_CTRL_ADDR, 8'hA9);
    rd(CSCS_CTRL_ADDR, 8'hA9);
    wr(CSCS_CTRL_ADDR, 8'h88);
    rd(CSCS_CTRL_ADDR, 8'h88);
    wr(CSCS_CTRL_ADDR, 8'h98);
    done(16'h0010);
    rd(CSCS_CTRL_ADDR, 8'hA8);
    wr(CSCS_CTRL_ADDR, 8'h80);
    wr(CSCS_CTRL_ADDR, 8'h90);
    done(16'hFFFF);
    rd(CSCS_CTRL_ADDR, 8'hA0);
    `CHK("start", 3, starts)
    rd(8'h55, 8'h00);
    results;
  end
endmodule

// ### verilog/cscs_cmp.sv
`timescale 1ns/1ns
module cscs_cmp
  import cscs_pkg::*;
(
  // comparator side of the carrier
  cscs_cmp_if.cmp cmp_if
);
  // disabled comparator never reports a hit
  always_comb
  begin
    cmp_if.hit = cmp_if.enable && cmp_if.result_valid &&
                 (cmp_if.result > cmp_if.threshold);
  end
endmodule

// ### verilog/cscs_ctrl.sv
`timescale 1ns/1ns
// Summary of operation
// - set done flag on every finished conversion
// - done flag cleared only by software
// - busy reads 1 during conversion only
// - comparator enable gates threshold compare
module cscs_ctrl
  import cscs_pkg::*;
#(
  parameter int RESULT_W = CSCS_RESULT_W
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // sfr access
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  // converter core
  input wire logic conv_done_in,
  input wire logic [RESULT_W-1:0] conv_result_in,
  input wire logic scan_done_in,
  input wire logic pin_monitor_in,
  output logic conv_start_out,
  output logic sense_enable_out
);
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic [7:0] thr_hi_ff;
  logic [7:0] nxt_thr_hi;
  logic [7:0] thr_lo_ff;
  logic [7:0] nxt_thr_lo;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic start_ff;
  logic nxt_start;
  logic ctrl_wr;
  logic [7:0] clr;

  cscs_cmp_if #(.W(RESULT_W)) cmp_bus ();

  assign cmp_bus.result = conv_result_in;
  assign cmp_bus.result_valid = conv_done_in;
  assign cmp_bus.threshold = RESULT_W'({thr_hi_ff, thr_lo_ff});
  assign cmp_bus.enable = ctrl_ff[CSCS_CMP_ENABLE_BIT];

  cscs_cmp u_cmp (
    .cmp_if(cmp_bus.cmp)
  );

  assign ctrl_wr = sfr_wr_in && (sfr_addr_in == CSCS_CTRL_ADDR);
  // writing 0 clears a flag, writing 1 leaves it alone
  assign clr = ctrl_wr ? ~sfr_wdata_in : 8'h00;

  // control and flags; an event in the clearing cycle wins
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_start = 1'b0;
    if (ctrl_wr)
    begin
      nxt_ctrl[CSCS_SENSE_ENABLE_BIT] = sfr_wdata_in[CSCS_SENSE_ENABLE_BIT];
      nxt_ctrl[CSCS_CMP_ENABLE_BIT] = sfr_wdata_in[CSCS_CMP_ENABLE_BIT];
    end
    nxt_ctrl[CSCS_END_OF_SCAN_BIT] = scan_done_in ||
      (ctrl_ff[CSCS_END_OF_SCAN_BIT] && !clr[CSCS_END_OF_SCAN_BIT]);
    nxt_ctrl[CSCS_CONV_DONE_BIT] = conv_done_in ||
      (ctrl_ff[CSCS_CONV_DONE_BIT] && !clr[CSCS_CONV_DONE_BIT]);
    nxt_ctrl[CSCS_PIN_MONITOR_BIT] = pin_monitor_in ||
      (ctrl_ff[CSCS_PIN_MONITOR_BIT] && !clr[CSCS_PIN_MONITOR_BIT]);
    nxt_ctrl[CSCS_CMP_FLAG_BIT] = cmp_bus.hit ||
      (ctrl_ff[CSCS_CMP_FLAG_BIT] && !clr[CSCS_CMP_FLAG_BIT]);
    // writing 1 to busy starts a conversion if enabled and idle
    if (ctrl_wr && sfr_wdata_in[CSCS_SENSE_BUSY_BIT] &&
        ctrl_ff[CSCS_SENSE_ENABLE_BIT] && !ctrl_ff[CSCS_SENSE_BUSY_BIT])
    begin
      nxt_start = 1'b1;
    end
    // busy holds from start until the converter reports done
    nxt_ctrl[CSCS_SENSE_BUSY_BIT] = nxt_start ||
      (ctrl_ff[CSCS_SENSE_BUSY_BIT] && !conv_done_in);
    // disabling the converter abandons a running conversion
    if (!nxt_ctrl[CSCS_SENSE_ENABLE_BIT])
    begin
      nxt_ctrl[CSCS_SENSE_BUSY_BIT] = 1'b0;
      nxt_start = 1'b0;
    end
    nxt_ctrl[CSCS_RESERVED_BIT] = 1'b0;
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ctrl_ff <= CSCS_CTRL_RESET;
      start_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      start_ff <= nxt_start;
    end
  end

  // threshold pair and read-back mux
  always_comb
  begin
    nxt_thr_hi = thr_hi_ff;
    nxt_thr_lo = thr_lo_ff;
    if (sfr_wr_in && (sfr_addr_in == CSCS_THR_HI_ADDR))
    begin
      nxt_thr_hi = sfr_wdata_in;
    end
    if (sfr_wr_in && (sfr_addr_in == CSCS_THR_LO_ADDR))
    begin
      nxt_thr_lo = sfr_wdata_in;
    end
    case (sfr_addr_in)
      CSCS_CTRL_ADDR: nxt_rdata = ctrl_ff;
      CSCS_THR_HI_ADDR: nxt_rdata = thr_hi_ff;
      CSCS_THR_LO_ADDR: nxt_rdata = thr_lo_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      thr_hi_ff <= CSCS_THR_RESET;
      thr_lo_ff <= CSCS_THR_RESET;
      rdata_ff <= 8'h00;
    end
    else
    begin
      thr_hi_ff <= nxt_thr_hi;
      thr_lo_ff <= nxt_thr_lo;
      rdata_ff <= nxt_rdata;
    end
  end

  assign sfr_rdata_out = rdata_ff;
  assign conv_start_out = start_ff;
  assign sense_enable_out = ctrl_ff[CSCS_SENSE_ENABLE_BIT];
endmodule
